// ---- hdl/sge_pkg.sv ----
package sge_pkg;
   localparam int REG_W = 8;
   localparam int FRAME_BITS = 16;

   // Register numbers carried by the three select bits
   localparam logic [2:0] REG_IN0 = 3'h0;
   localparam logic [2:0] REG_IN1 = 3'h1;
   localparam logic [2:0] REG_OUT0 = 3'h2;
   localparam logic [2:0] REG_OUT1 = 3'h3;
   localparam logic [2:0] REG_INV0 = 3'h4;
   localparam logic [2:0] REG_INV1 = 3'h5;
   localparam logic [2:0] REG_DIR0 = 3'h6;
   localparam logic [2:0] REG_DIR1 = 3'h7;

   localparam logic [7:0] RST_DRIVE = 8'hff;
   localparam logic [7:0] RST_INVERT = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hff;

   // Bit positions within a frame, counted from zero
   localparam logic [3:0] BIT_ADDR_LAST = 4'h2;
   localparam logic [3:0] BIT_DIR = 4'h3;
   localparam logic [3:0] BIT_ZERO = 4'h4;
   localparam logic [3:0] BIT_PIN_SAMPLE = 4'h6;
   localparam logic [3:0] BIT_CMD_LAST = 4'h7;
   localparam logic [3:0] BIT_DATA_LAST = 4'hf;
   localparam logic [2:0] TX_SHIFTS = 3'h7;

   // Timing
   localparam int SYS_CLK_NS = 40;
   localparam int SCLK_PERIOD_NS = 320;
   localparam int SCLK_HALF = (SCLK_PERIOD_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);

   // Controller software registers
   localparam logic [1:0] CR_DATA = 2'h0;
   localparam logic [1:0] CR_CMD = 2'h1;
   localparam logic [1:0] CR_STATUS = 2'h2;
   localparam int CMD_GO = 0;
   localparam int CMD_WRITE = 1;
   localparam int CMD_REG_LO = 2;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;

   typedef enum logic [2:0] {
      CS_IDLE,
      CS_LEAD,
      CS_LOW,
      CS_HIGH,
      CS_TAIL
   } sge_ctrl_state_t;

   function automatic logic [7:0] sge_reset_value(input logic [2:0] idx);
      if (idx == REG_INV0 || idx == REG_INV1) begin
         return RST_INVERT;
      end
      return RST_DRIVE;
   endfunction
endpackage

// ---- hdl/sge_spi_if.sv ----
`timescale 1ns/10ps
interface sge_spi_if;
   logic sclk;
   logic mosi;
   logic [2:0] cs_n;
   logic miso_o;
   logic miso_oe;
   logic miso;

   // Undriven line reads high, as with a pull-up
   assign miso = miso_oe ? miso_o : 1'b1;

   modport ctrl (
      output sclk,
      output mosi,
      output cs_n,
      input miso
   );

   modport dev (
      input sclk,
      input mosi,
      input cs_n,
      output miso_o,
      output miso_oe
   );
endinterface

// ---- hdl/sge_ctrl.sv ----
`timescale 1ns/10ps
module sge_ctrl #(
   parameter int SCLK_HALF = sge_pkg::SCLK_HALF
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Software port
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Link
   sge_spi_if.ctrl spi
);
   sge_pkg::sge_ctrl_state_t state_r;
   logic [7:0] div_r;
   logic [3:0] bit_r;
   logic [15:0] tx_r;
   logic [7:0] rx_r;
   logic [7:0] wdata_r;
   logic [7:0] rdata_r;
   logic [1:0] miso_q;
   logic sclk_r;
   logic mosi_r;
   logic cs_n_r;
   logic done_r;
   logic write_r;

   wire busy = state_r != sge_pkg::CS_IDLE;
   wire div_end = div_r == 8'(SCLK_HALF - 1);
   wire go = wr && addr == sge_pkg::CR_CMD && wdata[sge_pkg::CMD_GO] && !busy;
   wire done_set = state_r == sge_pkg::CS_TAIL && div_end;
   wire [7:0] status = {6'h00, done_r, busy};
   wire [7:0] rd_val = addr == sge_pkg::CR_DATA ? rx_r :
                       addr == sge_pkg::CR_STATUS ? status : 8'h00;
   // Command byte: select bits, direction, mandatory zero, three spare zeros
   wire [15:0] frame = {wdata[sge_pkg::CMD_REG_LO +: 3], wdata[sge_pkg::CMD_WRITE],
                        4'h0, wdata_r};

   assign spi.sclk = sclk_r;
   assign spi.mosi = mosi_r;
   assign spi.cs_n = {3{cs_n_r}};
   assign rdata = rdata_r;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         miso_q <= 2'h0;
         rdata_r <= 8'h00;
         wdata_r <= 8'h00;
         done_r <= 1'b0;
      end else begin
         miso_q <= {miso_q[0], spi.miso};
         if (rd) begin
            rdata_r <= rd_val;
         end
         if (wr && addr == sge_pkg::CR_DATA && !busy) begin
            wdata_r <= wdata;
         end
         // A finishing frame beats a clearing status read
         if (done_set) begin
            done_r <= 1'b1;
         end else if (rd && addr == sge_pkg::CR_STATUS) begin
            done_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= sge_pkg::CS_IDLE;
         div_r <= 8'h00;
         bit_r <= 4'h0;
         tx_r <= 16'h0000;
         rx_r <= 8'h00;
         sclk_r <= 1'b0;
         mosi_r <= 1'b0;
         cs_n_r <= 1'b1;
         write_r <= 1'b0;
      end else begin
         div_r <= (div_end || state_r == sge_pkg::CS_IDLE) ? 8'h00 : div_r + 8'h01;
         case (state_r)
            sge_pkg::CS_IDLE: begin
               if (go) begin
                  cs_n_r <= 1'b0;
                  tx_r <= frame;
                  write_r <= wdata[sge_pkg::CMD_WRITE];
                  state_r <= sge_pkg::CS_LEAD;
               end
            end
            sge_pkg::CS_LEAD: begin
               if (div_end) begin
                  mosi_r <= tx_r[15]; // R2
                  tx_r <= {tx_r[14:0], 1'b0};
                  bit_r <= 4'h0;
                  state_r <= sge_pkg::CS_LOW;
               end
            end
            sge_pkg::CS_LOW: begin
               if (div_end) begin
                  sclk_r <= 1'b1; // R1
                  state_r <= sge_pkg::CS_HIGH;
               end
            end
            sge_pkg::CS_HIGH: begin
               if (div_end) begin
                  // Sample just before the edge that moves the read data on
                  if (!write_r && bit_r > sge_pkg::BIT_CMD_LAST) begin
                     rx_r <= {rx_r[6:0], miso_q[1]};
                  end
                  sclk_r <= 1'b0;
                  if (bit_r == sge_pkg::BIT_DATA_LAST) begin
                     state_r <= sge_pkg::CS_TAIL;
                  end else begin
                     mosi_r <= tx_r[15];
                     tx_r <= {tx_r[14:0], 1'b0};
                     bit_r <= bit_r + 4'h1;
                     state_r <= sge_pkg::CS_LOW;
                  end
               end
            end
            sge_pkg::CS_TAIL: begin
               // Select is raised between frames, holding after the last fall
               if (div_end) begin
                  cs_n_r <= 1'b1; // R8
                  mosi_r <= 1'b0;
                  state_r <= sge_pkg::CS_IDLE;
               end
            end
            default: begin
               state_r <= sge_pkg::CS_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- hdl/sge_dev.sv ----
`timescale 1ns/10ps
// Summary of operation
// [R1] MOSI bits sampled on rising SCLK
// [R2] Frame: select bits MSB first, direction, zero, spares
// [R3] Direction bit high means register write
// [R4] Direction bit low means register read
// [R5] Bit after direction zero; three spares ignored
// [R6] Write data applied on following falling edge
// [R7] Act only when all three selects low
// [R8] Back-to-back frames accepted under held select
// [R9] MISO released except while returning read data
// [R10] Read: drive after fall, shift on falls
// [R11] Port pins latched third rise after direction
// [R12] Select bits decode eight registers zero to seven
// [R13] Writes to registers 0 and 1 ignored
// [R14] Input registers return live pin levels
// [R15] Output registers set driven pin level
// [R16] Reset sets output, direction registers all ones
// [R17] Polarity registers invert input reads, reset zero
// [R18] Polarity affects only input read-back
// [R19] Direction bit one input, zero drives
// [R20] Registers 2 to 7 read held value
// [R21] Register behaviour independent of host framing
// [R22] Deselect restarts the bit counter
// [R23] Driven pins still readable through input registers
module sge_dev (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic hard_reset_n,
   // Link
   sge_spi_if.dev spi,
   // Port 0 pins
   input wire logic [7:0] port0_pin_i,
   output logic [7:0] port0_pin_o,
   output logic [7:0] port0_pin_oe,
   // Port 1 pins
   input wire logic [7:0] port1_pin_i,
   output logic [7:0] port1_pin_o,
   output logic [7:0] port1_pin_oe
);
   logic [2:0] sclk_q;
   logic [1:0] mosi_q;
   logic [2:0] cs_q0;
   logic [2:0] cs_q1;
   logic [1:0] hr_q;
   logic [7:0] pin0_q0;
   logic [7:0] pin0_q1;
   logic [7:0] pin1_q0;
   logic [7:0] pin1_q1;
   logic [3:0] bit_cnt_r;
   logic [6:0] sr_r;
   logic [2:0] addr_r;
   logic wr_r;
   logic bad_r;
   logic [7:0] pin0_lat_r;
   logic [7:0] pin1_lat_r;
   logic rd_arm_r;
   logic [6:0] tx_r;
   logic [2:0] tx_cnt_r;
   logic miso_o_r;
   logic miso_oe_r;
   logic wr_pend_r;
   logic [7:0] wdata_r;
   logic [7:0] reg_r [2:7];
   logic [7:0] oe0_r;
   logic [7:0] oe1_r;

   wire sclk_s = sclk_q[1];
   wire mosi_s = mosi_q[1];
   wire sel = !(|cs_q1); // R7
   wire hr_low = !hr_q[1];
   wire rise = sel && sclk_s && !sclk_q[2]; // R1
   wire fall = sel && !sclk_s && sclk_q[2];
   wire [7:0] shifted = {sr_r, mosi_s};
   wire in_reg = addr_r == sge_pkg::REG_IN0 || addr_r == sge_pkg::REG_IN1;
   // Only the read-back path sees the inversion
   wire [7:0] in0_val = pin0_lat_r ^ reg_r[sge_pkg::REG_INV0]; // R17 R18 R23
   wire [7:0] in1_val = pin1_lat_r ^ reg_r[sge_pkg::REG_INV1]; // R17 R18 R23
   // Index into reg_r is taken only for numbers two and up
   wire [7:0] rd_val = addr_r == sge_pkg::REG_IN0 ? in0_val :
                       addr_r == sge_pkg::REG_IN1 ? in1_val :
                       reg_r[addr_r]; // R12 R14 R20
   wire cmd_done = rise && bit_cnt_r == sge_pkg::BIT_CMD_LAST;
   wire data_done = rise && bit_cnt_r == sge_pkg::BIT_DATA_LAST;
   wire wr_apply = fall && wr_pend_r; // R6

   assign spi.miso_o = miso_o_r;
   assign spi.miso_oe = miso_oe_r;
   assign port0_pin_o = reg_r[sge_pkg::REG_OUT0]; // R15
   assign port1_pin_o = reg_r[sge_pkg::REG_OUT1]; // R15
   assign port0_pin_oe = oe0_r;
   assign port1_pin_oe = oe1_r;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 3'h0;
         mosi_q <= 2'h0;
         cs_q0 <= 3'h7;
         cs_q1 <= 3'h7;
         hr_q <= 2'h0;
         pin0_q0 <= 8'h00;
         pin0_q1 <= 8'h00;
         pin1_q0 <= 8'h00;
         pin1_q1 <= 8'h00;
      end else begin
         sclk_q <= {sclk_q[1:0], spi.sclk};
         mosi_q <= {mosi_q[0], spi.mosi};
         cs_q0 <= spi.cs_n;
         cs_q1 <= cs_q0;
         hr_q <= {hr_q[0], hard_reset_n};
         pin0_q0 <= port0_pin_i;
         pin0_q1 <= pin0_q0;
         pin1_q0 <= port1_pin_i;
         pin1_q1 <= pin1_q0;
      end
   end

   // Receive side: command decode and write capture
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_r <= 4'h0;
         sr_r <= 7'h00;
         addr_r <= 3'h0;
         wr_r <= 1'b0;
         bad_r <= 1'b0;
         pin0_lat_r <= 8'h00;
         pin1_lat_r <= 8'h00;
         wr_pend_r <= 1'b0;
         wdata_r <= 8'h00;
      end else if (hr_low || !sel) begin
         bit_cnt_r <= 4'h0; // R22
         bad_r <= 1'b0;
         wr_pend_r <= 1'b0;
      end else begin
         if (rise) begin
            sr_r <= shifted[6:0];
            bit_cnt_r <= bit_cnt_r + 4'h1; // R8
            if (bit_cnt_r == sge_pkg::BIT_ADDR_LAST) begin
               addr_r <= shifted[2:0]; // R2
            end
            if (bit_cnt_r == sge_pkg::BIT_DIR) begin
               wr_r <= mosi_s; // R3 R4
            end
            // A set zero bit spoils the frame until the next deselect
            if (bit_cnt_r == sge_pkg::BIT_ZERO && mosi_s) begin
               bad_r <= 1'b1; // R5
            end
            if (bit_cnt_r == sge_pkg::BIT_PIN_SAMPLE) begin
               pin0_lat_r <= pin0_q1; // R11
               pin1_lat_r <= pin1_q1; // R11
            end
         end
         if (data_done && wr_r && !bad_r && !in_reg) begin
            wr_pend_r <= 1'b1; // R3 R13
            wdata_r <= shifted; // R6
         end else if (wr_apply) begin
            wr_pend_r <= 1'b0;
         end
      end
   end

   // Transmit side: read data on falling edges
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd_arm_r <= 1'b0;
         tx_r <= 7'h00;
         tx_cnt_r <= 3'h0;
         miso_o_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end else if (hr_low || !sel) begin
         rd_arm_r <= 1'b0;
         miso_oe_r <= 1'b0; // R9 R10
      end else begin
         if (cmd_done && !wr_r && !bad_r && !shifted[3]) begin
            rd_arm_r <= 1'b1; // R4
         end else if (fall && rd_arm_r) begin
            rd_arm_r <= 1'b0;
            miso_oe_r <= 1'b1; // R10
            miso_o_r <= rd_val[7];
            tx_r <= rd_val[6:0];
            tx_cnt_r <= sge_pkg::TX_SHIFTS;
         end else if (fall && miso_oe_r) begin
            if (tx_cnt_r != 3'h0) begin
               miso_o_r <= tx_r[6]; // R10
               tx_r <= {tx_r[5:0], 1'b0};
               tx_cnt_r <= tx_cnt_r - 3'h1;
            end else begin
               miso_oe_r <= 1'b0; // R9
            end
         end
      end
   end

   // Register file; written by the serial front end, reloaded by reset and hard reset
   generate
      for (genvar i = 2; i < 8; i++) begin : g_reg
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               reg_r[i] <= sge_pkg::sge_reset_value(3'(i)); // R16 R17
            end else if (hr_low) begin
               reg_r[i] <= sge_pkg::sge_reset_value(3'(i)); // R16 R21
            end else if (wr_apply && addr_r == 3'(i)) begin
               reg_r[i] <= wdata_r; // R6 R12
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         oe0_r <= 8'h00;
         oe1_r <= 8'h00;
      end else begin
         oe0_r <= ~reg_r[sge_pkg::REG_DIR0]; // R19
         oe1_r <= ~reg_r[sge_pkg::REG_DIR1]; // R19
      end
   end
endmodule

// ---- test/sge_sva.sv ----
`timescale 1ns/10ps
module sge_sva (
   // Clock and reset
   input logic sys_clk,
   input logic rstn,
   // Link
   input logic sclk,
   input logic mosi,
   input logic [2:0] cs_n,
   input logic miso_o,
   input logic miso_oe,
   input logic miso
);
   logic sclk_r;
   logic [4:0] rise_cnt_r;
   logic [3:0] fall_cnt_r;
   wire sel = (cs_n == 3'h0);
   wire sclk_rise = sclk && !sclk_r;
   wire sclk_fall = !sclk && sclk_r;

   // Counts follow the pin edges, so device-side sync delay shows as slack below
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_r <= 1'b0;
         rise_cnt_r <= 5'h00;
         fall_cnt_r <= 4'hf;
      end else begin
         sclk_r <= sclk;
         rise_cnt_r <= !sel ? 5'h00 : rise_cnt_r + {4'h0, sclk_rise};
         fall_cnt_r <= sclk_fall ? 4'h0 : fall_cnt_r + {3'h0, fall_cnt_r != 4'hf};
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence read_start;
      $rose(miso_oe);
   endsequence
   sequence deselected;
      (!sel) [*6];
   endsequence

   sel_equal_a:
      assert property (cs_n == 3'h0 || cs_n == 3'h7) else $error("selects differ");
   idle_clock_a:
      assert property (!sel |-> !sclk) else $error("link clock runs while deselected");
   mosi_hold_a:
      assert property (sclk |-> $stable(mosi)) else $error("mosi moved while clock high");
   high_phase_a:
      assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("clock high phase length");
   frame_count_a:
      assert property ($rose(!sel) |-> rise_cnt_r == 5'h10) else $error("frame not sixteen bits");
   drive_start_a:
      assert property (read_start |-> sel && rise_cnt_r inside {5'h08, 5'h09})
         else $error("miso driven at wrong bit");
   drive_end_a:
      assert property ($fell(miso_oe) && sel |-> rise_cnt_r == 5'h10)
         else $error("miso released at wrong bit");
   miso_release_a:
      assert property (deselected |-> !miso_oe) else $error("miso driven while deselected");
   zero_bit_a:
      assert property (sel && sclk_rise && rise_cnt_r == 5'h04 |-> !mosi)
         else $error("command zero bit set");
   shift_fall_a:
      assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> fall_cnt_r inside {[1:7]})
         else $error("miso changed away from falling edge");
   idle_high_a:
      assert property (!miso_oe |-> miso) else $error("released miso not high");
endmodule

// ---- test/spi_gpio_expander_regs_bench.sv ----
`timescale 1ns/10ps
module spi_gpio_expander_regs_bench;
   logic sys_clk;
   logic rstn;
   logic hard_reset_n;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic [7:0] p0_o, p0_oe, p1_o, p1_oe, ext0, ext1, q;
   logic [7:0] val [8];
   int fail_count;
   int checks;
   // Pins read back their own drive where enabled, the outside level elsewhere
   wire [7:0] p0_lvl = (p0_o & p0_oe) | (ext0 & ~p0_oe);
   wire [7:0] p1_lvl = (p1_o & p1_oe) | (ext1 & ~p1_oe);

   sge_spi_if spi ();
   sge_ctrl #(.SCLK_HALF(4)) i_sge_ctrl (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .spi(spi));
   sge_dev i_sge_dev (.sys_clk(sys_clk), .rstn(rstn), .hard_reset_n(hard_reset_n), .spi(spi),
      .port0_pin_i(p0_lvl), .port0_pin_o(p0_o), .port0_pin_oe(p0_oe),
      .port1_pin_i(p1_lvl), .port1_pin_o(p1_o), .port1_pin_oe(p1_oe));
   sge_sva i_sge_sva (.sys_clk(sys_clk), .rstn(rstn), .sclk(spi.sclk), .mosi(spi.mosi),
      .cs_n(spi.cs_n), .miso_o(spi.miso_o), .miso_oe(spi.miso_oe), .miso(spi.miso));

   task results;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task sw_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   task sw_rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // One whole link frame through the controller; q is the byte read back
   task frame(input logic w, input int r, input logic [7:0] d);
      logic [7:0] st;
      int n;
      st = 8'h00;
      n = 0;
      sw_wr(sge_pkg::CR_DATA, d);
      sw_wr(sge_pkg::CR_CMD, (8'h01 << sge_pkg::CMD_GO) | ({7'h00, w} << sge_pkg::CMD_WRITE)
         | ({5'h00, r[2:0]} << sge_pkg::CMD_REG_LO));
      while (st[sge_pkg::ST_DONE] !== 1'b1 && n < 300) begin
         sw_rd(sge_pkg::CR_STATUS, st);
         // The first poll lands well inside the frame
         if (n == 0) begin
            chk({7'h00, st[sge_pkg::ST_BUSY]}, 8'h01);
         end
         n++;
      end
      chk({7'h00, st[sge_pkg::ST_DONE]}, 8'h01);
      chk({7'h00, st[sge_pkg::ST_BUSY]}, 8'h00);
      sw_rd(sge_pkg::CR_DATA, q);
   endtask

   task s_defaults;
      for (int i = 2; i < 8; i++) begin
         frame(1'b0, i, 8'h00);
         chk(q, (i == 4 || i == 5) ? 8'h00 : 8'hff);
      end
      chk(p0_o, 8'hff);
      chk(p1_oe, 8'h00);
   endtask

   task verify;
      for (int i = 2; i < 8; i++) begin
         frame(1'b0, i, 8'h00);
         chk(q, val[i]);
      end
      chk(p0_o, val[2]);
      chk(p1_o, val[3]);
      chk(p0_oe, ~val[6]);
      chk(p1_oe, ~val[7]);
   endtask

   task s_write;
      for (int i = 2; i < 8; i++) begin
         val[i] = 8'h3c ^ 8'(i * 8'h27);
         frame(1'b1, i, val[i]);
      end
      verify();
   endtask

   // Writes aimed at the input registers must leave every register alone
   task s_readonly;
      frame(1'b1, 0, 8'h00);
      frame(1'b1, 1, 8'hff);
      verify();
   endtask

   task s_input;
      @(posedge sys_clk);
      ext0 <= 8'hc3;
      ext1 <= 8'h96;
      frame(1'b0, 0, 8'h00);
      chk(q, ((val[2] & ~val[6]) | (8'hc3 & val[6])) ^ val[4]);
      frame(1'b0, 1, 8'h00);
      chk(q, ((val[3] & ~val[7]) | (8'h96 & val[7])) ^ val[5]);
   endtask

   task s_hard;
      @(posedge sys_clk);
      hard_reset_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      hard_reset_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      s_defaults();
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   initial begin
      #(40 * 40000);
      fail_count++;
      results();
   end

   initial begin
      rstn = 1'b0;
      hard_reset_n = 1'b1;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ext0 = 8'h00;
      ext1 = 8'h00;
      fail_count = 0;
      checks = 0;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      s_defaults();
      s_write();
      s_readonly();
      s_input();
      s_hard();
      results();
   end
endmodule
